// file: rtl/tlih_top.v
// Contract
// - source event sets its pending flag regardless of enables.
// - request only when pending, global enable and source enable set.
// - CPU finishes instruction then long-calls the source vector.
// - return resumes at the instruction that would have run next.
// - disabled sources are ignored; program flow continues normally.
// - auto-clear sources clear on vectoring; others cleared by software.
// - flag still set after return: re-enter after one instruction.
// - each source has its own enable bit.
// - source enables count only once global enable bit 7 is one.
// - global enable clear blocks every source.
// - events while globally disabled stay pending until re-enabled.
// - software writing one to pending acts as a real event.
// - each source has its own priority level bit.
// - high level preempts low; low resumes after high returns.
// - a high-level routine is never preempted.
// - all priority bits reset to zero.
// - higher level first, then fixed order within a level.
// - pending sampled and priority resolved every clock cycle; the code samples pending only in cycles with i_ce high.
// - equal or higher active: wait for return plus one instruction.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "tlih_map.vh"
module tlih_top #(
   parameter N_SRC = 19,
   parameter IW    = 5,
   // sources whose pending flag clears on vectoring (first four)
   parameter [18:0] AUTO_CLR = 19'h0000F
) (
   input  wire             i_clk_sys,
   input  wire             i_sys_rst,
   input  wire             i_ce,
   // apb
   input  wire             i_psel,
   input  wire             i_penable,
   input  wire             i_pwrite,
   input  wire [11:0]      i_paddr,
   input  wire [31:0]      i_pwdata,
   output wire             o_pready,
   output wire             o_pslverr,
   output wire [31:0]      o_prdata,
   // peripheral sources
   input  wire [N_SRC-1:0] i_src_event,
   input  wire [N_SRC-1:0] i_src_clr,
   // cpu sequencer
   input  wire             i_instr_done,
   input  wire             i_ret_done,
   input  wire             i_call_ack,
   output reg              o_call_req,
   output reg  [15:0]      o_call_vec,
   output wire [N_SRC-1:0] o_pending
);
   localparam ST_RUN  = 2'h0;
   localparam ST_HOLD = 2'h1;
   localparam ST_CALL = 2'h2;

   reg  [N_SRC-1:0] pend_q;
   reg  [N_SRC-1:0] pend_d;
   reg  [1:0]       st_q;
   reg  [1:0]       st_d;
   reg              in_lo_q;
   reg              in_hi_q;
   reg              hold_q;
   reg  [IW-1:0]    win_q;
   reg              win_hi_q;
   wire             gie;
   wire [N_SRC-1:0] en;
   wire [N_SRC-1:0] pri;
   wire [N_SRC-1:0] sw_set;
   wire [N_SRC-1:0] sw_clr;
   wire [N_SRC-1:0] req;
   wire             arb_valid;
   wire             arb_high;
   wire [IW-1:0]    arb_idx;
   wire             may_take;
   wire             can_take;
   wire             take_now;
   wire             fire;

   function [15:0] vec_of;
      input [IW-1:0] idx;
      begin
         vec_of = `TLIH_VEC_BASE + {8'h00, idx, 3'h0};
      end
   endfunction

   assign o_pending = pend_q;

   assign req = gie ? (pend_q & en) : {N_SRC{1'b0}};

   tlih_arbiter #(
      .N_SRC   (N_SRC),
      .IW      (IW)
   ) u_arb (
      .i_req   (req),
      .i_pri   (pri),
      .o_valid (arb_valid),
      .o_high  (arb_high),
      .o_idx   (arb_idx)
   );

   tlih_apb_regs #(
      .N_SRC     (N_SRC)
   ) u_regs (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_ce      (i_ce),
      .i_psel    (i_psel),
      .i_penable (i_penable),
      .i_pwrite  (i_pwrite),
      .i_paddr   (i_paddr),
      .i_pwdata  (i_pwdata),
      .i_pend    (pend_q),
      .i_status  ({25'h0000000, in_hi_q, in_lo_q, st_q, hold_q,
                   o_call_req, arb_valid}),
      .o_pready  (o_pready),
      .o_pslverr (o_pslverr),
      .o_prdata  (o_prdata),
      .o_gie     (gie),
      .o_en      (en),
      .o_pri     (pri),
      .o_sw_set  (sw_set),
      .o_sw_clr  (sw_clr)
   );

   assign can_take = arb_valid & ~in_hi_q & (~in_lo_q | arb_high);
   assign may_take = can_take & ~hold_q;
   assign take_now = can_take & hold_q & i_instr_done;
   // call raised at the edge that ends an instruction
   assign fire     = (st_q == ST_HOLD && can_take && i_instr_done) ||
                     (st_q == ST_RUN && take_now);

   // pending flags: set wins over clear
   always @* begin
      pend_d = pend_q & ~sw_clr & ~i_src_clr;
      if (st_q == ST_CALL && i_call_ack) begin
         pend_d = pend_d & ~(AUTO_CLR[N_SRC-1:0] &
                  ({{(N_SRC-1){1'b0}}, 1'b1} << win_q));
      end
      pend_d = pend_d | i_src_event | sw_set;
   end

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_RUN: begin
            if (take_now) begin
               st_d = ST_CALL;
            end else if (may_take) begin
               st_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!can_take) begin
               st_d = ST_RUN;
            end else if (i_instr_done) begin
               st_d = ST_CALL;
            end
         end
         ST_CALL: begin
            if (i_call_ack) begin
               st_d = ST_RUN;
            end
         end
         default: st_d = ST_RUN;
      endcase
   end

   // pending flags and sequencer state
   always @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         pend_q <= {N_SRC{1'b0}};
         st_q   <= ST_RUN;
      end else if (i_ce) begin
         pend_q <= pend_d;
         st_q   <= st_d;
      end
   end

   // call request towards the sequencer
   always @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         win_q      <= {IW{1'b0}};
         win_hi_q   <= 1'b0;
         o_call_req <= 1'b0;
         o_call_vec <= 16'h0000;
      end else if (i_ce) begin
         if (fire) begin
            win_q      <= arb_idx;
            win_hi_q   <= arb_high;
            o_call_req <= 1'b1;
            o_call_vec <= vec_of(arb_idx);
         end else if (st_q == ST_CALL && i_call_ack) begin
            o_call_req <= 1'b0;
         end
      end
   end

   // in-service levels and the one-instruction hold after a return
   always @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         in_lo_q <= 1'b0;
         in_hi_q <= 1'b0;
         hold_q  <= 1'b0;
      end else if (i_ce) begin
         if (st_q == ST_CALL && i_call_ack) begin
            if (win_hi_q) begin
               in_hi_q <= 1'b1;
            end else begin
               in_lo_q <= 1'b1;
            end
         end
         if (i_ret_done) begin
            if (in_hi_q) begin
               in_hi_q <= 1'b0;
            end else begin
               in_lo_q <= 1'b0;
            end
            hold_q <= 1'b1;
         end else if (i_instr_done) begin
            hold_q <= 1'b0;
         end
      end
   end
endmodule // tlih_top

// file: inc/tlih_map.vh
`ifndef TLIH_MAP_VH
`define TLIH_MAP_VH
// register byte addresses
`define TLIH_ADDR_BASIC_EN   12'h000
`define TLIH_ADDR_EXT_EN     12'h004
`define TLIH_ADDR_BASIC_PRI  12'h008
`define TLIH_ADDR_EXT_PRI    12'h00C
`define TLIH_ADDR_PEND       12'h010
`define TLIH_ADDR_PEND_SET   12'h014
`define TLIH_ADDR_PEND_CLR   12'h018
`define TLIH_ADDR_STATUS     12'h01C
// field positions
`define TLIH_GIE_BIT         7
`define TLIH_BASIC_SRCS      7
// reset values
`define TLIH_RST_ZERO        32'h0000_0000
// vector spacing and base
`define TLIH_VEC_BASE        16'h0003
`define TLIH_VEC_STEP        4'h8
`endif

// file: rtl/tlih_arbiter.v
`timescale 1ns/1ps
// picks the winning source: high level first, then lowest index
module tlih_arbiter #(
   parameter N_SRC = 19,
   parameter IW    = 5
) (
   input  wire [N_SRC-1:0] i_req,
   input  wire [N_SRC-1:0] i_pri,
   output reg              o_valid,
   output reg              o_high,
   output reg  [IW-1:0]    o_idx
);
   integer k;
   reg [N_SRC-1:0] hi_req;
   reg [N_SRC-1:0] sel;

   always @* begin
      hi_req  = i_req & i_pri;
      sel     = (|hi_req) ? hi_req : i_req;
      o_valid = |i_req;
      o_high  = |hi_req;
      o_idx   = {IW{1'b0}};
      for (k = N_SRC - 1; k >= 0; k = k - 1) begin
         if (sel[k]) begin
            o_idx = k[IW-1:0];
         end
      end
   end
endmodule // tlih_arbiter

// file: rtl/tlih_apb_regs.v
`timescale 1ns/1ps
`include "tlih_map.vh"
// apb slave: enables, priorities, pending set/clear, status readback
module tlih_apb_regs #(
   parameter N_SRC = 19
) (
   input  wire             i_clk_sys,
   input  wire             i_sys_rst,
   input  wire             i_ce,
   input  wire             i_psel,
   input  wire             i_penable,
   input  wire             i_pwrite,
   input  wire [11:0]      i_paddr,
   input  wire [31:0]      i_pwdata,
   input  wire [N_SRC-1:0] i_pend,
   input  wire [31:0]      i_status,
   output wire             o_pready,
   output wire             o_pslverr,
   output reg  [31:0]      o_prdata,
   output reg              o_gie,
   output reg  [N_SRC-1:0] o_en,
   output reg  [N_SRC-1:0] o_pri,
   output wire [N_SRC-1:0] o_sw_set,
   output wire [N_SRC-1:0] o_sw_clr
);
   localparam NB = `TLIH_BASIC_SRCS;
   localparam NE = N_SRC - NB;

   wire acc = i_psel & i_penable & i_ce;
   wire wr  = acc & i_pwrite;
   reg  hit;

   always @* begin
      case (i_paddr)
         `TLIH_ADDR_BASIC_EN, `TLIH_ADDR_EXT_EN, `TLIH_ADDR_BASIC_PRI,
         `TLIH_ADDR_EXT_PRI, `TLIH_ADDR_PEND, `TLIH_ADDR_PEND_SET,
         `TLIH_ADDR_PEND_CLR, `TLIH_ADDR_STATUS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~hit;

   assign o_sw_set = (wr && i_paddr == `TLIH_ADDR_PEND_SET) ?
                     i_pwdata[N_SRC-1:0] : {N_SRC{1'b0}};
   assign o_sw_clr = (wr && i_paddr == `TLIH_ADDR_PEND_CLR) ?
                     i_pwdata[N_SRC-1:0] : {N_SRC{1'b0}};

   always @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_gie <= 1'b0;
         o_en  <= {N_SRC{1'b0}};
         o_pri <= {N_SRC{1'b0}};
         o_prdata <= `TLIH_RST_ZERO;
      end else if (i_ce) begin
         if (wr) begin
            case (i_paddr)
               `TLIH_ADDR_BASIC_EN: begin
                  o_gie        <= i_pwdata[`TLIH_GIE_BIT];
                  o_en[NB-1:0] <= i_pwdata[NB-1:0];
               end
               `TLIH_ADDR_EXT_EN:
                  o_en[N_SRC-1:NB] <= i_pwdata[NE-1:0];
               `TLIH_ADDR_BASIC_PRI:
                  o_pri[NB-1:0] <= i_pwdata[NB-1:0];
               `TLIH_ADDR_EXT_PRI:
                  o_pri[N_SRC-1:NB] <= i_pwdata[NE-1:0];
               default: ;
            endcase
         end
         if (i_psel & ~i_penable & ~i_pwrite) begin
            case (i_paddr)
               `TLIH_ADDR_BASIC_EN:
                  o_prdata <= {24'h000000, o_gie, o_en[NB-1:0]};
               `TLIH_ADDR_EXT_EN:
                  o_prdata <= {{(32-NE){1'b0}}, o_en[N_SRC-1:NB]};
               `TLIH_ADDR_BASIC_PRI:
                  o_prdata <= {25'h0000000, o_pri[NB-1:0]};
               `TLIH_ADDR_EXT_PRI:
                  o_prdata <= {{(32-NE){1'b0}}, o_pri[N_SRC-1:NB]};
               `TLIH_ADDR_PEND:
                  o_prdata <= {{(32-N_SRC){1'b0}}, i_pend};
               `TLIH_ADDR_STATUS: o_prdata <= i_status;
               default: o_prdata <= `TLIH_RST_ZERO;
            endcase
         end
      end
   end
endmodule // tlih_apb_regs

// file: test/tlih_top_props.sv
`timescale 1ns/1ps
module tlih_top_props #(
   parameter N_SRC = 19
) (
   input wire             i_clk_sys,
   input wire             i_sys_rst,
   input wire             i_ce,
   input wire [N_SRC-1:0] i_src_event,
   input wire             i_instr_done,
   input wire             i_ret_done,
   input wire             i_call_ack,
   input wire             o_call_req,
   input wire [15:0]      o_call_vec,
   input wire [N_SRC-1:0] o_pending
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   property p_ev_set;
      i_ce && |i_src_event |=>
         (o_pending & $past(i_src_event)) == $past(i_src_event);
   endproperty
   a_ev_set: assert property (p_ev_set)
      else $error("event lost");
   property p_rise;
      $rose(o_call_req) |-> $past(i_instr_done) && $past(|o_pending);
   endproperty
   a_rise: assert property (p_rise)
      else $error("call without cause");
   property p_hold;
      o_call_req && !i_call_ack |=> o_call_req && $stable(o_call_vec);
   endproperty
   a_hold: assert property (p_hold)
      else $error("call not held");
   property p_drop;
      o_call_req && i_call_ack && i_ce |=> !o_call_req;
   endproperty
   a_drop: assert property (p_drop)
      else $error("call not dropped");
   property p_vec;
      o_call_req |-> o_call_vec[2:0] == 3'h3 && o_call_vec[15:3] < N_SRC;
   endproperty
   a_vec: assert property (p_vec)
      else $error("bad vector");
   property p_auto;
      o_call_req && i_call_ack && i_ce && o_call_vec < 16'h0020
         && !(|i_src_event) |=> !o_pending[$past(o_call_vec[4:3])];
   endproperty
   a_auto: assert property (p_auto)
      else $error("no auto clear");
   property p_gap;
      i_ret_done && !i_instr_done && !o_call_req |=> !o_call_req;
   endproperty
   a_gap: assert property (p_gap)
      else $error("call too soon");
   property p_rst;
      disable iff (1'b0)
      i_sys_rst && i_ce |=> !o_call_req && o_pending == 0;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset state");
   c_call: cover property (o_call_req && i_call_ack);
   c_ret: cover property (i_ret_done);
   c_hi: cover property (o_call_req && o_call_vec == 16'h004B);
endmodule // tlih_top_props
bind tlih_top tlih_top_props #(.N_SRC(N_SRC)) u_props (
   .i_clk_sys(i_clk_sys),
   .i_sys_rst(i_sys_rst),
   .i_ce(i_ce),
   .i_src_event(i_src_event),
   .i_instr_done(i_instr_done),
   .i_ret_done(i_ret_done),
   .i_call_ack(i_call_ack),
   .o_call_req(o_call_req),
   .o_call_vec(o_call_vec),
   .o_pending(o_pending)
);

// file: test/tlih_cpu_model.sv
`timescale 1ns/1ps
module tlih_cpu_model (
   input  wire i_clk_sys,
   input  wire i_sys_rst,
   input  wire i_call_req,
   input  wire i_slow,
   input  wire i_ret_go,
   output reg  o_instr_done,
   output reg  o_call_ack,
   output reg  o_ret_done
);
   reg [1:0] cnt_q;
   reg [1:0] dep_q;
   always @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         cnt_q <= 2'h0;
         dep_q <= 2'h0;
         o_instr_done <= 1'b0;
         o_call_ack <= 1'b0;
         o_ret_done <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         o_instr_done <= (!i_slow || cnt_q == 2'h3) && !i_ret_go;
         o_call_ack <= i_call_req && !o_call_ack && (!i_slow || cnt_q[0]);
         o_ret_done <= i_ret_go && dep_q != 2'h0;
         dep_q <= dep_q + {1'b0, o_call_ack} - {1'b0, o_ret_done};
      end
   end
endmodule // tlih_cpu_model

// file: test/tlih_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
   err_count = err_count + 1; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tlih_tb_top;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         psel = 1'b0;
   reg         pen = 1'b0;
   reg         pwr = 1'b0;
   reg  [11:0] pa = 12'h000;
   reg  [31:0] pwd = 32'h0000_0000;
   reg  [18:0] ev = 19'h00000;
   reg  [18:0] scl = 19'h00000;
   reg         slow = 1'b0;
   reg         rgo = 1'b0;
   reg         ce = 1'b1;
   wire        prdy;
   wire        perr;
   wire [31:0] prd;
   wire        idn;
   wire        rdn;
   wire        ack;
   wire        creq;
   wire [15:0] cvec;
   wire [18:0] pend;
   integer     err_count = 0;
   integer     n_tests = 0;
   integer     i;
   reg  [31:0] rd;
   reg         se;
   tlih_top uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_ce(ce),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
      .i_pwdata(pwd), .o_pready(prdy), .o_pslverr(perr), .o_prdata(prd),
      .i_src_event(ev), .i_src_clr(scl), .i_instr_done(idn),
      .i_ret_done(rdn), .i_call_ack(ack), .o_call_req(creq),
      .o_call_vec(cvec), .o_pending(pend));
   tlih_cpu_model u_cpu (.i_clk_sys(clk), .i_sys_rst(rst),
      .i_call_req(creq), .i_slow(slow), .i_ret_go(rgo),
      .o_instr_done(idn), .o_call_ack(ack), .o_ret_done(rdn));
   initial forever #12.5 clk = ~clk;
   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task hang;
      begin
         `CHK("timeout", 1'b0, 1'b1)
         tally_and_finish;
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      integer k;
      begin
         psel <= 1'b1;
         pwr <= w;
         pa <= a;
         pwd <= d;
         @(posedge clk);
         pen <= 1'b1;
         k = 0;
         @(posedge clk);
         while (prdy !== 1'b1) begin
            k = k + 1;
            if (k > 20) hang;
            @(posedge clk);
         end
         rd = prd;
         se = perr;
         psel <= 1'b0;
         pen <= 1'b0;
         @(posedge clk);
      end
   endtask
   task want(input [15:0] v);
      integer k;
      begin
         k = 0;
         @(negedge clk);
         while (creq !== 1'b1) begin
            k = k + 1;
            if (k > 60) hang;
            @(negedge clk);
         end
         `CHK("vector", v, cvec)
         while (creq === 1'b1) begin
            k = k + 1;
            if (k > 90) hang;
            @(negedge clk);
         end
         rd = {13'h0000, pend};
         @(posedge clk);
      end
   endtask
   task nocall;
      begin
         se = 1'b0;
         repeat (12) begin
            @(negedge clk);
            se = se | creq;
         end
         `CHK("no call", 1'b0, se)
         @(posedge clk);
      end
   endtask
   task ret;
      begin
         rgo <= 1'b1;
         @(posedge clk);
         rgo <= 1'b0;
         @(posedge clk);
      end
   endtask
   task pulse(input [18:0] m, input c);
      begin
         if (c)
            scl <= m;
         else
            ev <= m;
         @(posedge clk);
         scl <= 19'h00000;
         ev <= 19'h00000;
         @(posedge clk);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 5; i = i + 1) begin
         apb(1'b0, 12'(4 * i), 32'h0000_0000);
         `CHK("reset value", 32'h0000_0000, rd)
      end
      ce <= 1'b0;
      apb(1'b1, 12'h008, 32'h0000_007F);
      ce <= 1'b1;
      apb(1'b0, 12'h008, 32'h0000_0000);
      `CHK("frozen write", 32'h0000_0000, rd)
      pulse(19'h00020, 1'b0);
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK("pending", 32'h0000_0020, rd)
      apb(1'b1, 12'h000, 32'h0000_0020);
      nocall;
      apb(1'b1, 12'h000, 32'h0000_00A0);
      want(16'h002B);
      ret;
      want(16'h002B);
      pulse(19'h00020, 1'b1);
      ret;
      pulse(19'h00040, 1'b0);
      nocall;
      apb(1'b0, 12'h020, 32'h0000_0000);
      `CHK("slverr", 1'b1, se)
      `CHK("unmapped read", 32'h0000_0000, rd)
      apb(1'b1, 12'h000, 32'h0000_0081);
      pulse(19'h00001, 1'b0);
      want(16'h0003);
      `CHK("auto clear", 1'b0, rd[0])
      ret;
      apb(1'b1, 12'h004, 32'h0000_0001);
      apb(1'b1, 12'h014, 32'h0000_0080);
      want(16'h003B);
      apb(1'b1, 12'h018, 32'h0000_0080);
      ret;
      apb(1'b1, 12'h000, 32'h0000_0098);
      apb(1'b1, 12'h014, 32'h0000_0018);
      want(16'h001B);
      ret;
      want(16'h0023);
      apb(1'b1, 12'h018, 32'h0000_0010);
      ret;
      slow <= 1'b1;
      apb(1'b1, 12'h000, 32'h0000_0084);
      apb(1'b1, 12'h004, 32'h0000_0004);
      apb(1'b1, 12'h00C, 32'h0000_0004);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      `CHK("priority", 32'h0000_0004, rd)
      apb(1'b1, 12'h014, 32'h0000_0204);
      want(16'h004B);
      nocall;
      apb(1'b1, 12'h018, 32'h0000_0200);
      ret;
      want(16'h0013);
      pulse(19'h00200, 1'b0);
      want(16'h004B);
      apb(1'b1, 12'h018, 32'h0000_0200);
      ret;
      ret;
      nocall;
      apb(1'b1, 12'h014, 32'h0000_0004);
      want(16'h0013);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, 12'h000, 32'h0000_0000);
      `CHK("enable after reset", 32'h0000_0000, rd)
      apb(1'b0, 12'h01C, 32'h0000_0000);
      `CHK("status after reset", 32'h0000_0000, rd)
      tally_and_finish;
   end
endmodule // tlih_tb_top
